//--- acsr_cell_status.v
// ATM cell status reporter with APB registers and interrupt
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`include "acsr_regs.vh"
`default_nettype none
module acsr_cell_status #(
    parameter integer REPEAT_CYCLES = `ACSR_REPEAT_MS * `ACSR_CLK_KHZ
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         irq,
    input  wire [1:0]  delin_state,
    input  wire        hec_fail,
    input  wire        frame_tick,
    input  wire        sync_word_loss,
    input  wire        ncd_failure,
    input  wire        lcd_failure,
    input  wire        rx_valid,
    input  wire [7:0]  rx_byte,
    input  wire        tx_ready,
    output wire        tx_valid,
    output wire [7:0]  tx_byte,
    output wire        tx_last
);

reg  [1:0]  ctrl_reg;
reg  [2:0]  status_reg;
reg  [2:0]  mask_reg;
reg  [1:0]  dstate_reg;
reg         acquired_reg;
reg         ncd_reg;
reg         ocd_reg;
reg         lcd_reg;
reg         ocd_frame_reg;
reg  [3:0]  frame_cnt_reg;
reg  [15:0] hvc_reg;
reg  [15:0] last_hvc_reg;
reg         fail_prev_reg;
reg         auto_reg;
reg  [31:0] timer_reg;
reg         pending_reg;
reg         send_now_reg;

wire        fail_any;
wire        fail_rise;
wire        req_rx;
wire        tick;
wire        ser_busy;
wire        take;
wire [7:0]  flags;
wire [31:0] msg;
wire        hec_ind;
wire        acc;
wire        wr;
wire        rd_status;
wire [2:0]  ev_set;
wire [2:0]  status_next;
reg  [31:0] rdata_next;
reg         addr_ok;

// Delineation state history and out-of-delineation anomaly
always @(posedge clk)
begin
    if (!rstn)
    begin
        dstate_reg   <= `ACSR_DS_HUNT;
        acquired_reg <= 1'b0;
        ocd_reg      <= 1'b0;
    end
    else
    begin
        dstate_reg <= delin_state;
        if (delin_state == `ACSR_DS_SYNC)
            acquired_reg <= 1'b1;
        if (dstate_reg == `ACSR_DS_SYNC && delin_state == `ACSR_DS_HUNT && acquired_reg)
            ocd_reg <= 1'b1;
        else if ((dstate_reg == `ACSR_DS_PRESYNC && delin_state == `ACSR_DS_SYNC) || lcd_reg)
            ocd_reg <= 1'b0;
    end
end

// Line frames that saw the anomaly, counted up to the defect threshold
always @(posedge clk)
begin
    if (!rstn)
    begin
        ocd_frame_reg <= 1'b0;
        frame_cnt_reg <= 4'h0;
    end
    else if (delin_state == `ACSR_DS_SYNC)
    begin
        // Stale history must not re-declare the defect after a later slip
        ocd_frame_reg <= 1'b0;
        frame_cnt_reg <= 4'h0;
    end
    else if (frame_tick)
    begin
        // Frame boundary closes the window of the current line frame
        ocd_frame_reg <= ocd_reg;
        if (!(ocd_frame_reg || ocd_reg) || sync_word_loss)
            frame_cnt_reg <= 4'h0;
        else if (frame_cnt_reg != `ACSR_LCD_FRAMES)
            frame_cnt_reg <= frame_cnt_reg + 4'h1;
    end
    else if (ocd_reg)
        ocd_frame_reg <= 1'b1;
end

// Loss-of-delineation defect, held until sync returns
always @(posedge clk)
begin
    if (!rstn)
        lcd_reg <= 1'b0;
    else if (delin_state == `ACSR_DS_SYNC)
        lcd_reg <= 1'b0;
    else if (frame_cnt_reg == `ACSR_LCD_FRAMES && !sync_word_loss)
        lcd_reg <= 1'b1;
end

// No-delineation holds from start-up until first sync
always @(posedge clk)
begin
    if (!rstn)
        ncd_reg <= 1'b1;
    else
        ncd_reg <= !acquired_reg && delin_state != `ACSR_DS_SYNC;
end

// Violation count, free running
always @(posedge clk)
begin
    if (!rstn)
        hvc_reg <= 16'h0000;
    else if (hec_fail)
        hvc_reg <= hvc_reg + 16'h0001;
end

// Priority keeps the three flags one-hot or clear
assign flags[`ACSR_BIT_NCD]      = ncd_reg;
assign flags[`ACSR_BIT_OCD]      = ocd_reg && !ncd_reg && !lcd_reg;
assign flags[`ACSR_BIT_LCD]      = lcd_reg && !ncd_reg;
assign flags[4:2]                = 3'h0;
assign flags[`ACSR_BIT_NCD_FAIL] = ncd_failure;
assign flags[`ACSR_BIT_LCD_FAIL] = lcd_failure;

assign msg     = {`ACSR_MSG_INFO, flags, hvc_reg[15:8], hvc_reg[7:0]};
assign hec_ind = (hvc_reg != last_hvc_reg);

assign fail_any  = ncd_failure || lcd_failure;
assign fail_rise = fail_any && !fail_prev_reg;
assign req_rx    = rx_valid && rx_byte == `ACSR_MSG_REQ;
assign tick      = auto_reg && timer_reg == 32'h00000001;
assign take      = pending_reg && !ser_busy;

// Unsolicited reporting and repeat timer
always @(posedge clk)
begin
    if (!rstn)
    begin
        fail_prev_reg <= 1'b0;
        auto_reg      <= 1'b0;
        timer_reg     <= 32'h00000000;
    end
    else
    begin
        fail_prev_reg <= fail_any;
        if (req_rx || !fail_any || !ctrl_reg[`ACSR_CTRL_AUTO_EN])
            auto_reg <= 1'b0;
        else if (fail_rise)
            auto_reg <= 1'b1;
        // One-second enable pulse restarts when a failure begins while no other failure is active
        if (!auto_reg || fail_rise || tick)
            timer_reg <= REPEAT_CYCLES;
        else
            timer_reg <= timer_reg - 32'h00000001;
    end
end

// Pending report: a new cause wins over the take
always @(posedge clk)
begin
    if (!rstn)
    begin
        pending_reg  <= 1'b0;
        last_hvc_reg <= 16'h0000;
    end
    else
    begin
        pending_reg <= req_rx
                    || (fail_rise && ctrl_reg[`ACSR_CTRL_AUTO_EN])
                    || tick
                    || send_now_reg
                    || (pending_reg && !take);
        if (take)
            last_hvc_reg <= hvc_reg;
    end
end

acsr_tx_ser u_ser (
    .clk      (clk),
    .rstn     (rstn),
    .load     (take),
    .msg      (msg),
    .tx_ready (tx_ready),
    .tx_valid (tx_valid),
    .tx_byte  (tx_byte),
    .tx_last  (tx_last),
    .busy     (ser_busy)
);

// APB slave, no wait state: ready and read data are registered from the setup cycle
assign acc       = psel && penable && pready;
assign wr        = acc && pwrite;
assign rd_status = acc && !pwrite && paddr == `ACSR_ADDR_STATUS;

assign ev_set[`ACSR_EV_SENT] = take;
assign ev_set[`ACSR_EV_REQ]  = req_rx;
assign ev_set[`ACSR_EV_FAIL] = fail_rise;
// Only the bits that were returned are cleared, so late events survive
assign status_next = (status_reg & ~(rd_status ? prdata[2:0] : 3'h0)) | ev_set;

always @*
begin
    rdata_next = 32'h00000000;
    addr_ok    = 1'b1;
    case (paddr)
        `ACSR_ADDR_CTRL:   rdata_next = {31'h0, ctrl_reg[`ACSR_CTRL_AUTO_EN]};
        `ACSR_ADDR_STATUS: rdata_next = {29'h0, status_reg};
        `ACSR_ADDR_MASK:   rdata_next = {29'h0, mask_reg};
        `ACSR_ADDR_STATE:  rdata_next = {22'h0, auto_reg, hec_ind, flags};
        `ACSR_ADDR_COUNT:  rdata_next = {last_hvc_reg, hvc_reg};
        default:           addr_ok    = 1'b0;
    endcase
end

// Bus side: ready, read data and error
always @(posedge clk)
begin
    if (!rstn)
    begin
        prdata  <= 32'h00000000;
        pready  <= 1'b0;
        pslverr <= 1'b0;
    end
    else
    begin
        pready <= psel && !penable;
        if (psel && !penable)
        begin
            prdata  <= pwrite ? 32'h00000000 : rdata_next;
            pslverr <= !addr_ok;
        end
        else
            pslverr <= 1'b0;
    end
end

// Sticky events and the level interrupt one cycle behind
always @(posedge clk)
begin
    if (!rstn)
    begin
        status_reg <= 3'h0;
        irq        <= 1'b0;
    end
    else
    begin
        status_reg <= status_next;
        irq        <= |(status_reg & mask_reg);
    end
end

// Writable registers take effect in the access cycle
always @(posedge clk)
begin
    if (!rstn)
    begin
        ctrl_reg     <= `ACSR_CTRL_RESET;
        mask_reg     <= 3'h0;
        send_now_reg <= 1'b0;
    end
    else
    begin
        send_now_reg <= 1'b0;
        if (wr && paddr == `ACSR_ADDR_CTRL)
        begin
            ctrl_reg[`ACSR_CTRL_AUTO_EN] <= pwdata[`ACSR_CTRL_AUTO_EN];
            send_now_reg                 <= pwdata[`ACSR_CTRL_SEND];
        end
        if (wr && paddr == `ACSR_ADDR_MASK)
            mask_reg <= pwdata[2:0];
    end
end

endmodule
`default_nettype wire

//--- acsr_regs.vh
// Constants for the ATM cell status reporter
// Operation
// - A status request (identifier 17) is answered with a status message whose first octet is 145.
// - A status message is also sent unasked when a persistent no-delineation or loss-of-delineation failure begins; sent only if the other was not active.
// - While unasked reporting runs the message repeats every second, stopping on a request 17 or when the failure clears.
// - Octet two holds the no-delineation flag at bit 7, out-of-delineation at bit 6, loss-of-delineation at bit 5, 1 meaning alarm.
// - Octet two bit 1 reports the persistent no-delineation failure and bit 0 the persistent loss-of-delineation failure.
// - Octets three and four hold the 16-bit violation count, high byte first.
// - The header error indicator is 1 when the count differs from the one in the last report, else 0.
// - At most one of the three delineation flags is 1 in any message.
// - The three flags follow the current no-delineation anomaly, out-of-delineation anomaly and loss-of-delineation defect.
// - The violation count steps once per received cell whose header check fails.
// - Loss of delineation is declared after out-of-delineation in 9 consecutive line frames with no sync-word loss.
// - Out-of-delineation begins when the delineation process falls from synchronised back to hunting.
`ifndef ACSR_REGS_VH
`define ACSR_REGS_VH

`define ACSR_MSG_INFO       8'h91
`define ACSR_MSG_REQ        8'h11

`define ACSR_BIT_NCD        7
`define ACSR_BIT_OCD        6
`define ACSR_BIT_LCD        5
`define ACSR_BIT_NCD_FAIL   1
`define ACSR_BIT_LCD_FAIL   0

`define ACSR_DS_HUNT        2'h0
`define ACSR_DS_PRESYNC     2'h1
`define ACSR_DS_SYNC        2'h2

`define ACSR_LCD_FRAMES     4'h9

`define ACSR_REPEAT_MS      1000
`define ACSR_CLK_KHZ        40000

`define ACSR_ADDR_CTRL      8'h00
`define ACSR_ADDR_STATUS    8'h04
`define ACSR_ADDR_MASK      8'h08
`define ACSR_ADDR_STATE     8'h0c
`define ACSR_ADDR_COUNT     8'h10

`define ACSR_CTRL_RESET     2'h1
`define ACSR_CTRL_AUTO_EN   0
`define ACSR_CTRL_SEND      1

`define ACSR_EV_SENT        0
`define ACSR_EV_REQ         1
`define ACSR_EV_FAIL        2
`define ACSR_EV_WIDTH       3

`endif

//--- acsr_tx_ser.v
// Byte serializer for one four-octet status message
`default_nettype none
module acsr_tx_ser (
    input  wire        clk,
    input  wire        rstn,
    input  wire        load,
    input  wire [31:0] msg,
    input  wire        tx_ready,
    output reg         tx_valid,
    output reg  [7:0]  tx_byte,
    output reg         tx_last,
    output wire        busy
);

reg [23:0] rest_reg;
reg [1:0]  left_reg;

assign busy = tx_valid;

always @(posedge clk)
begin
    if (!rstn)
    begin
        tx_valid <= 1'b0;
        tx_byte  <= 8'h00;
        tx_last  <= 1'b0;
        rest_reg <= 24'h000000;
        left_reg <= 2'h0;
    end
    else if (load && !tx_valid)
    begin
        // Octet one leaves first, the rest follow in order
        tx_valid <= 1'b1;
        tx_byte  <= msg[31:24];
        tx_last  <= 1'b0;
        rest_reg <= msg[23:0];
        left_reg <= 2'h3;
    end
    else if (tx_valid && tx_ready)
    begin
        if (left_reg == 2'h0)
        begin
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
        end
        else
        begin
            tx_byte  <= rest_reg[23:16];
            rest_reg <= {rest_reg[15:0], 8'h00};
            left_reg <= left_reg - 2'h1;
            tx_last  <= (left_reg == 2'h1);
        end
    end
end

endmodule
`default_nettype wire

//--- acsr_cs_props.sv
// Concurrent checks on the cell status reporter ports
`default_nettype none
module acsr_cs_props (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       tx_ready,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic       tx_last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] idx_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_stall;
        tx_valid && !tx_ready;
    endsequence
    // Octet position, back to zero after the last octet
    always @(posedge clk)
    begin
        if (!rstn)
            idx_reg <= 2'h0;
        else if (tx_valid && tx_ready)
            idx_reg <= tx_last ? 2'h0 : idx_reg + 2'h1;
    end
    a_setup_ready: assert property (s_setup |=> pready) else $error("no ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
    a_err_ready: assert property (pslverr |-> pready) else $error("lone error");
    a_unmapped_err: assert property (s_setup ##0 (paddr > 8'h10 || paddr[1:0] != 2'h0)
        |=> pslverr) else $error("no error");
    a_first_octet: assert property (tx_valid && idx_reg == 2'h0 |-> tx_byte == 8'h91)
        else $error("bad identifier");
    a_flags_onehot: assert property (tx_valid && idx_reg == 2'h1 |-> $onehot0(tx_byte[7:5]))
        else $error("two flags");
    a_rsvd_zero: assert property (tx_valid && idx_reg == 2'h1 |-> tx_byte[4:2] == 3'h0)
        else $error("reserved set");
    a_byte_hold: assert property (s_stall |=> tx_valid && $stable(tx_byte))
        else $error("octet dropped");
    a_last_octet: assert property (tx_valid |-> tx_last == (idx_reg == 2'h3))
        else $error("bad length");
endmodule
`default_nettype wire

//--- acsr_ltu_model.sv
// Line termination unit stand-in: collects reports, sends requests
`default_nettype none
module acsr_ltu_model (
    input  wire logic       clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_last,
    output var  logic       tx_ready,
    output var  logic       rx_valid,
    output var  logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] acc;
    logic [31:0] msgs[$];
    initial
    begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
    end
    // Random stalls, so octets must stand until taken
    always @(posedge clk)
    begin
        tx_ready <= 1'($urandom_range(0, 1));
        if (tx_valid && tx_ready)
        begin
            acc <= {acc[15:0], tx_byte};
            if (tx_last)
                msgs.push_back({acc, tx_byte});
        end
    end
    // Request, also confirms an unasked report
    task send_req;
        rx_valid <= 1'b1;
        rx_byte  <= 8'h11;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte  <= 8'hee;
    endtask
endmodule
`default_nettype wire

//--- acsr_cell_status_bench.sv
// Self-checking bench for the cell status reporter
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module acsr_cell_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REP = 50;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic        hec_fail, frame_tick, sync_word_loss, ncd_failure, lcd_failure;
    logic        rx_valid, tx_ready, tx_valid, tx_last, m_ncd, m_ocd, m_lcd, m_nf, m_lf;
    logic [1:0]  delin_state;
    logic [7:0]  paddr, rx_byte, tx_byte;
    logic [31:0] pwdata, prdata, rd;
    int          mismatches, n_checks, m_cnt, m_last;
    acsr_cell_status #(.REPEAT_CYCLES(REP)) acsr_cell_status_i (.clk(clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .delin_state(delin_state), .hec_fail(hec_fail), .frame_tick(frame_tick),
        .sync_word_loss(sync_word_loss), .ncd_failure(ncd_failure), .lcd_failure(lcd_failure),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_last(tx_last));
    acsr_ltu_model acsr_ltu_model_i (.clk(clk), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] exp_msg();
        return {8'h91, m_ncd, m_ocd, m_lcd, 3'h0, m_nf, m_lf, m_cnt[15:0]};
    endfunction
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One APB transfer; waits for ready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++)
            @(posedge clk);
        if (pready !== 1'b1)
        begin
            mismatches++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic get_msg(input logic [31:0] e, input string n);
        int i;
        logic [31:0] got;
        for (i = 0; i < 400 && acsr_ltu_model_i.msgs.size() == 0; i++)
            @(posedge clk);
        if (acsr_ltu_model_i.msgs.size() == 0)
        begin
            mismatches++;
            final_report();
        end
        got = acsr_ltu_model_i.msgs.pop_front();
        `CHK(n, e, got)
    endtask
    task frames(input int c);
        repeat (c)
        begin
            frame_tick <= 1'b1;
            @(posedge clk);
            frame_tick <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic quiet(input int c);
        repeat (c) @(posedge clk);
        `CHK("silence", 1'b1, acsr_ltu_model_i.msgs.size() == 0)
    endtask
    task pulse_hec;
        hec_fail <= 1'b1;
        @(posedge clk);
        hec_fail <= 1'b0;
        @(posedge clk);
        m_cnt++;
    endtask
    initial
    begin
        void'($urandom(32'h23b7));
        {psel, penable, pwrite, hec_fail, frame_tick, sync_word_loss} = '0;
        {ncd_failure, lcd_failure, rstn, m_ocd, m_lcd, m_nf, m_lf} = '0;
        {paddr, pwdata, delin_state} = '0;
        m_ncd = 1'b1;
        m_cnt = $urandom_range(0, 0);
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h1, rd)
        apb(1'b0, 8'h24, 32'h0);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, 8'h08, 32'h7);
        acsr_ltu_model_i.send_req();
        get_msg(exp_msg(), "no delineation");
        `CHK("irq", 1'b1, irq)
        apb(1'b0, 8'h04, 32'h0);
        `CHK("status", 32'h3, rd)
        @(posedge clk);
        `CHK("irq clear", 1'b0, irq)
        delin_state <= 2'h2;
        m_ncd = 1'b0;
        repeat ($urandom_range(3, 12)) pulse_hec();
        acsr_ltu_model_i.send_req();
        get_msg(exp_msg(), "count");
        m_last = m_cnt;
        pulse_hec();
        apb(1'b0, 8'h0c, 32'h0);
        `CHK("hec indicator", 1'b1, rd[8])
        apb(1'b0, 8'h10, 32'h0);
        `CHK("count reg", {m_last[15:0], m_cnt[15:0]}, rd)
        delin_state <= 2'h0;
        m_ocd = 1'b1;
        @(posedge clk);
        acsr_ltu_model_i.send_req();
        get_msg(exp_msg(), "out of delineation");
        frames(8);
        apb(1'b0, 8'h0c, 32'h0);
        `CHK("state", 32'h40, rd)
        frames(2);
        m_lcd = 1'b1;
        m_ocd = 1'b0;
        acsr_ltu_model_i.send_req();
        get_msg(exp_msg(), "loss of delineation");
        lcd_failure <= 1'b1;
        m_lf = 1'b1;
        get_msg(exp_msg(), "unasked");
        quiet(20);
        get_msg(exp_msg(), "repeat");
        acsr_ltu_model_i.send_req();
        get_msg(exp_msg(), "confirmed");
        quiet(3 * REP);
        lcd_failure <= 1'b0;
        m_lf = 1'b0;
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        ncd_failure <= 1'b1;
        m_nf = 1'b1;
        get_msg(exp_msg(), "failure");
        `CHK("irq masked", 1'b0, irq)
        ncd_failure <= 1'b0;
        m_nf = 1'b0;
        quiet(3 * REP);
        apb(1'b0, 8'h04, 32'h0);
        `CHK("status fail", 32'h5, rd)
        apb(1'b1, 8'h00, 32'h2);
        get_msg(exp_msg(), "send now");
        lcd_failure <= 1'b1;
        m_lf = 1'b1;
        quiet(3 * REP);
        apb(1'b0, 8'h00, 32'h0);
        `CHK("ctrl off", 32'h0, rd)
        delin_state <= 2'h1;
        @(posedge clk);
        delin_state <= 2'h2;
        m_lcd = 1'b0;
        @(posedge clk);
        acsr_ltu_model_i.send_req();
        get_msg(exp_msg(), "resync");
        final_report();
    end
endmodule
bind acsr_cell_status acsr_cs_props acsr_cs_props_i (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last));
`default_nettype wire
